// ### bundle_pkg.sv
package bundle_pkg;

    // Bundle geometry.
    localparam int BUNDLE_BITS  = 128;
    localparam int SLOT_BITS    = 41;
    localparam int TMPL_BITS    = 5;
    localparam int BUNDLE_BYTES = 16;
    localparam int ADDR_LSB     = 4;
    localparam int PC_BITS      = 64 - ADDR_LSB;

    // Field positions inside a bundle and inside a slot.
    localparam int TMPL_LSB  = 0;
    localparam int SLOT0_LSB = 5;
    localparam int SLOT1_LSB = 46;
    localparam int SLOT2_LSB = 87;
    localparam int OPC_LSB   = 37;
    localparam int X6_LSB    = 27;
    localparam int X3_LSB    = 33;

    // Values after reset.
    localparam logic [PC_BITS-1:0] RESET_PC = 60'h0;

    // Major opcodes of note.
    localparam logic [3:0]  LONG_BR_OPC   = 4'hC;
    localparam logic [3:0]  LONG_CALL_OPC = 4'hD;
    localparam logic [15:0] A_OPC_MASK    = 16'h7300;
    localparam logic [15:0] RESV_B_MASK   = 16'hFF48;

    // Execution unit type controlled by a slot, and executing units.
    typedef enum logic [2:0] {
        U_M = 3'h0,
        U_I = 3'h1,
        U_F = 3'h2,
        U_B = 3'h3,
        U_L = 3'h4,
        U_X = 3'h5
    } unit_e;

    // The six instruction types.
    typedef enum logic [2:0] {
        T_A  = 3'h0,
        T_I  = 3'h1,
        T_M  = 3'h2,
        T_F  = 3'h3,
        T_B  = 3'h4,
        T_LX = 3'h5
    } itype_e;

    // Sequencer states.
    typedef enum logic [2:0] {
        S_FETCH = 3'h0,
        S_LOAD  = 3'h1,
        S_ISSUE = 3'h2,
        S_DRAIN = 3'h3,
        S_FAULT = 3'h4
    } seq_e;

endpackage

// ### decode_if.sv
`timescale 1ns/100ps
interface decode_if;
    import bundle_pkg::*;

    logic [TMPL_BITS-1:0] tmpl;
    unit_e                slotUnit [3];
    logic [2:0]           stopAfter;
    logic                 tmplLegal;
    logic [SLOT_BITS-1:0] instr;
    unit_e                curUnit;
    unit_e                execUnit;
    itype_e               itype;
    logic                 isBreakB;
    logic                 isResvB;

    modport tdec (input tmpl, output slotUnit, stopAfter, tmplLegal);
    modport cls  (input instr, curUnit,
                  output execUnit, itype, isBreakB, isResvB);
    modport seq  (output tmpl, instr, curUnit,
                  input slotUnit, stopAfter, tmplLegal,
                  input execUnit, itype, isBreakB, isResvB);
endinterface // decode_if

// ### template_decoder.sv
`timescale 1ns/100ps
module template_decoder
    import bundle_pkg::*;
(
    // Decode lanes.
    decode_if.tdec d
);

    // Slot units and stops from the template; odd codes add a final stop.
    always_comb
    begin
        d.tmplLegal = 1'b1;
        d.stopAfter = d.tmpl[0] ? 3'b100 : 3'b000;
        d.slotUnit[0] = U_M;
        d.slotUnit[1] = U_I;
        d.slotUnit[2] = U_I;
        unique case (d.tmpl[4:1])
            4'h0: ;
            4'h1: d.stopAfter[1] = 1'b1;
            4'h2:
            begin
                d.slotUnit[1] = U_L;
                d.slotUnit[2] = U_X;
            end
            4'h4: d.slotUnit[1] = U_M;
            4'h5:
            begin
                d.slotUnit[1] = U_M;
                d.stopAfter[0] = 1'b1;
            end
            4'h6: d.slotUnit[1] = U_F;
            4'h7:
            begin
                d.slotUnit[1] = U_M;
                d.slotUnit[2] = U_F;
            end
            4'h8: d.slotUnit[2] = U_B;
            4'h9:
            begin
                d.slotUnit[1] = U_B;
                d.slotUnit[2] = U_B;
            end
            4'hB:
            begin
                d.slotUnit[0] = U_B;
                d.slotUnit[1] = U_B;
                d.slotUnit[2] = U_B;
            end
            4'hC:
            begin
                d.slotUnit[1] = U_M;
                d.slotUnit[2] = U_B;
            end
            4'hE:
            begin
                d.slotUnit[1] = U_F;
                d.slotUnit[2] = U_B;
            end
            default: d.tmplLegal = 1'b0; // Undefined templates.
        endcase
    end

endmodule // template_decoder

// ### slot_classifier.sv
`timescale 1ns/100ps
module slot_classifier
    import bundle_pkg::*;
(
    // Decode lanes.
    decode_if.cls c
);

    logic [3:0] opc;

    assign opc = c.instr[OPC_LSB +: 4];

    // Instruction type and executing unit for the slot being issued.
    always_comb
    begin
        c.isBreakB = 1'b0;
        c.isResvB  = 1'b0;
        c.execUnit = c.curUnit;
        c.itype    = T_LX;
        unique case (c.curUnit)
            U_M: c.itype = A_OPC_MASK[opc] ? T_A : T_M;
            U_I: c.itype = A_OPC_MASK[opc] ? T_A : T_I;
            U_F: c.itype = T_F;
            U_B:
            begin
                c.itype    = T_B;
                c.isBreakB = (opc == 4'h0) &&
                             (c.instr[X6_LSB +: 6] == 6'h00);
                c.isResvB  = RESV_B_MASK[opc];
            end
            U_X:
            begin
                if (opc == 4'h0 && c.instr[X3_LSB +: 3] == 3'h0)
                begin
                    c.itype    = T_I; // Integer break and no-op accepted.
                    c.execUnit = U_I;
                end
                else if (opc == LONG_BR_OPC || opc == LONG_CALL_OPC)
                    c.execUnit = U_B;
                else
                    c.execUnit = U_I;
            end
            U_L: c.execUnit = U_I;
            default: c.execUnit = U_I;
        endcase
    end

endmodule // slot_classifier

// ### bundle_decode_group_sequencer.sv
`timescale 1ns/100ps
module bundle_decode_group_sequencer
    import bundle_pkg::*;
(
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Instruction fetch path.
    output logic                        fetchReq,
    output logic [63:0]                 fetchAddr,
    input  wire logic                   fetchValid,
    input  wire logic [BUNDLE_BYTES-1:0][7:0] fetchBytes,
    // Issue towards the execution units.
    output logic                        issueValid,
    input  wire logic                   issueReady,
    output logic [SLOT_BITS-1:0]        issueInstr,
    output logic [SLOT_BITS-1:0]        issueExtra,
    output unit_e                       issueUnit,
    output itype_e                      issueType,
    output logic [63:0]                 issueAddr,
    output logic [1:0]                  issueSlot,
    output logic                        issueGroupStart,
    output logic                        issueGroupEnd,
    output logic                        issueNoDep,
    // Feedback from the execution units.
    input  wire logic                   redirectValid,
    input  wire logic [63:0]            redirectAddr,
    input  wire logic                   redirectEndsGroup,
    input  wire logic                   serializeReq,
    input  wire logic                   updatesDone,
    // Group phase and fault reporting.
    output logic                        regCommit,
    output logic                        illegalOp,
    output logic [63:0]                 faultAddr
);

    typedef struct packed {
        seq_e                   state;
        logic [PC_BITS-1:0]     pc;
        logic [PC_BITS-1:0]     reqPc;
        logic [BUNDLE_BITS-1:0] bundle;
        logic [1:0]             slot;
        logic                   drop;
        logic                   serialWait;
        logic                   fresh;
        logic                   groupOpen;
        logic                   needFetch;
        logic [SLOT_BITS-1:0]   instr;
        logic [SLOT_BITS-1:0]   extra;
        unit_e                  unit;
        itype_e                 itype;
        logic [PC_BITS-1:0]     ipc;
        logic [1:0]             islot;
        logic                   gStart;
        logic                   gEnd;
        logic                   noDep;
        logic                   commit;
        logic                   illegal;
    } seq_s;

    seq_s                   r;
    seq_s                   next_r;
    decode_if               dl ();
    logic [BUNDLE_BITS-1:0] fetched;
    logic [SLOT_BITS-1:0]   slotWord [3];
    logic                   isLong;
    logic                   lastSlot;
    logic [2:0]             stopHere;

    // Byte k of the bundle sits at bits 8k+7..8k whatever data order
    // the load/store side uses, so the template is always byte zero.
    assign fetched = fetchBytes;

    // Slot fields of the held bundle.
    assign dl.tmpl     = r.bundle[TMPL_LSB +: TMPL_BITS];
    assign slotWord[0] = r.bundle[SLOT0_LSB +: SLOT_BITS];
    assign slotWord[1] = r.bundle[SLOT1_LSB +: SLOT_BITS];
    assign slotWord[2] = r.bundle[SLOT2_LSB +: SLOT_BITS];

    // A long slot pairs with the extended slot that follows it.
    assign isLong     = dl.slotUnit[r.slot] == U_L;
    assign dl.instr   = isLong ? slotWord[2] : slotWord[r.slot];
    assign dl.curUnit = isLong ? U_X : dl.slotUnit[r.slot];
    assign lastSlot   = isLong || r.slot == 2'd2;
    assign stopHere   = dl.stopAfter;

    template_decoder u_tdec (
        .d (dl)
    );

    slot_classifier u_cls (
        .c (dl)
    );

    // Next-state logic for fetch, slot walk and group boundaries.
    always_comb
    begin
        next_r         = r;
        next_r.commit  = 1'b0;
        next_r.illegal = 1'b0;
        // An update completion and a new serialising op in one cycle
        // leave the wait armed.
        if (serializeReq)
            next_r.serialWait = 1'b1;
        else if (updatesDone)
            next_r.serialWait = 1'b0;
        unique case (r.state)
            S_FETCH:
            begin
                if (fetchValid && r.drop)
                    next_r.drop = 1'b0;
                else if (fetchValid)
                begin
                    next_r.bundle = fetched;
                    next_r.slot   = 2'd0;
                    next_r.state  = S_LOAD;
                end
            end
            S_LOAD:
            begin
                if (!dl.tmplLegal)
                begin
                    next_r.illegal = 1'b1;
                    next_r.state   = S_FAULT;
                end
                else
                begin
                    next_r.instr  = dl.instr;
                    next_r.extra  = isLong ? slotWord[1] : '0;
                    next_r.unit   = dl.execUnit;
                    next_r.itype  = dl.itype;
                    next_r.ipc    = r.pc;
                    next_r.islot  = r.slot;
                    next_r.gStart = !r.groupOpen;
                    next_r.noDep  = r.fresh;
                    // Only branch-unit break and reserved branch
                    // encodings close a group besides stops.
                    next_r.gEnd   = stopHere[isLong ? 2'd2 : r.slot] ||
                                    dl.isBreakB || dl.isResvB;
                    next_r.state  = S_ISSUE;
                end
            end
            S_ISSUE:
            begin
                if (issueReady)
                begin
                    next_r.fresh     = 1'b0;
                    next_r.groupOpen = !r.gEnd;
                    next_r.needFetch = lastSlot;
                    if (lastSlot)
                        next_r.pc = r.pc + 1'b1;
                    else
                        next_r.slot = r.slot + 1'b1;
                    if (r.gEnd)
                    begin
                        // Release the group's held register updates.
                        next_r.commit = 1'b1;
                        next_r.state  = S_DRAIN;
                    end
                    else
                        next_r.state = lastSlot ? S_FETCH : S_LOAD;
                end
            end
            S_DRAIN:
            begin
                // The next group reads only after all updates land.
                if (updatesDone)
                    next_r.state = r.needFetch ? S_FETCH : S_LOAD;
            end
            S_FAULT: ;
            default: next_r.state = S_FAULT;
        endcase
        // A redirect flushes the wrong path and starts at slot zero.
        if (redirectValid)
        begin
            next_r.pc    = redirectAddr[63:ADDR_LSB];
            next_r.slot  = 2'd0;
            next_r.fresh = 1'b1;
            next_r.drop  = r.drop ||
                           (r.state == S_FETCH && fetchReq && !fetchValid);
            next_r.needFetch = 1'b1;
            if (redirectEndsGroup && r.groupOpen)
            begin
                next_r.groupOpen = 1'b0;
                next_r.commit    = 1'b1;
                next_r.state     = S_DRAIN;
            end
            else
                next_r.state = S_FETCH;
        end
        // The request address follows the pc unless stale data is due.
        if (!next_r.drop)
            next_r.reqPc = next_r.pc;
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            r            <= '0;
            r.state      <= S_FETCH;
            r.pc         <= RESET_PC;
            r.reqPc      <= RESET_PC;
            r.fresh      <= 1'b1;
            r.unit       <= U_M;
            r.itype      <= T_M;
        end
        else
            r <= next_r;
    end

    // Fetch handshake; a serialising op holds new fetches back.
    assign fetchReq  = (r.state == S_FETCH && !r.serialWait) ||
                       r.drop;
    assign fetchAddr = {r.reqPc, 4'h0};

    // Issue handshake and registered slot data.
    assign issueValid      = r.state == S_ISSUE;
    assign issueInstr      = r.instr;
    assign issueExtra      = r.extra;
    assign issueUnit       = r.unit;
    assign issueType       = r.itype;
    assign issueAddr       = {r.ipc, 4'h0};
    assign issueSlot       = r.islot;
    assign issueGroupStart = r.gStart;
    assign issueGroupEnd   = r.gEnd;
    assign issueNoDep      = r.noDep;

    // Group commit pulse, fault flag and the current bundle address.
    assign regCommit = r.commit;
    assign illegalOp = r.illegal;
    assign faultAddr = {r.pc, 4'h0};

endmodule // bundle_decode_group_sequencer

// ### bundle_seq_sva.sv
`timescale 1ns/100ps
module bundle_seq_checker
    import bundle_pkg::*;
(
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rst_n,
    // Fetch and issue.
    input wire logic        fetchReq,
    input wire logic        fetchValid,
    input wire logic [63:0] fetchAddr,
    input wire logic        issueValid,
    input wire logic        issueReady,
    input wire logic [63:0] issueAddr,
    input wire logic        issueGroupEnd,
    // Feedback and status.
    input wire logic        redirectValid,
    input wire logic [63:0] redirectAddr,
    input wire logic        redirectEndsGroup,
    input wire logic        serializeReq,
    input wire logic        updatesDone,
    input wire logic        regCommit,
    input wire logic        illegalOp
);
    // All checks use the core clock and rest while reset is applied.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Bundle addresses on fetch and issue keep the low four bits clear.
    fetch_align_a:
        assert property ((fetchReq || issueValid) |->
            (fetchAddr[3:0] | issueAddr[3:0]) == 4'h0)
        else $error("bundle address not aligned");
    // One slot is offered at a time, so an accepted slot drops valid.
    single_issue_a:
        assert property (issueValid && issueReady && !redirectValid |=>
            !issueValid)
        else $error("slot offered twice");
    // The last slot of a group commits the deferred register writes.
    commit_at_end_a:
        assert property (issueValid && issueReady && issueGroupEnd &&
            !redirectValid |=> regCommit)
        else $error("group end without commit");
    // In the cycle a group commits nothing new is issued or fetched.
    drain_hold_a:
        assert property (regCommit |-> !issueValid && !fetchReq)
        else $error("activity during group drain");
    // A serialising op holds fetch until the updates are reported done.
    serial_hold_a:
        assert property (serializeReq && !updatesDone && !redirectValid
            ##1 !updatesDone && !redirectValid |-> !fetchReq)
        else $error("fetch during serialise wait");
    // A redirect that does not end the group fetches the aligned target on the next cycle.
    redirect_fetch_a:
        assert property (redirectValid && !redirectEndsGroup |=> fetchReq
            && fetchAddr == ($past(redirectAddr) & 64'hFFFF_FFFF_FFFF_FFF0))
        else $error("redirect target not fetched");
    // A bad template dispatches no slot.
    fault_quiet_a:
        assert property (illegalOp |-> !issueValid ##1 !issueValid)
        else $error("slot issued from bad bundle");
    // Fetched data is loaded for one cycle before a slot is offered.
    load_gap_a:
        assert property (fetchReq && fetchValid && !redirectValid
            ##1 !redirectValid |-> !issueValid ##1 (issueValid || illegalOp))
        else $error("bundle load timing wrong");
endmodule // bundle_seq_checker

bind bundle_decode_group_sequencer bundle_seq_checker CHK (
    .clk(clk), .rst_n(rst_n), .fetchReq(fetchReq), .fetchValid(fetchValid),
    .fetchAddr(fetchAddr), .issueValid(issueValid), .issueReady(issueReady),
    .issueAddr(issueAddr), .issueGroupEnd(issueGroupEnd),
    .redirectValid(redirectValid), .redirectAddr(redirectAddr),
    .redirectEndsGroup(redirectEndsGroup), .serializeReq(serializeReq),
    .updatesDone(updatesDone), .regCommit(regCommit), .illegalOp(illegalOp));

// ### fetch_exec_model.sv
`timescale 1ns/100ps
module fetch_exec_model
    import bundle_pkg::*;
(
    // Clock, reset and pace.
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    slow,
    // Fetch path.
    input  wire logic                    fetchReq,
    input  wire logic [63:0]             fetchAddr,
    output logic                         fetchValid,
    output logic [BUNDLE_BYTES-1:0][7:0] fetchBytes,
    // Execution units.
    input  wire logic                    issueValid,
    output logic                         issueReady,
    input  wire logic                    regCommit,
    input  wire logic                    serializeReq,
    output logic                         updatesDone
);
    logic [BUNDLE_BITS-1:0] mem [16];
    logic [2:0]             fetchWait;
    logic [2:0]             doneWait;
    logic [1:0]             pace;
    logic                   fetchBusy;
    logic                   doneBusy;

    // Memory answers one request at a time; released data is inverted.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            fetchValid <= 1'b0;
            fetchBusy  <= 1'b0;
            fetchBytes <= '0;
        end
        else if (fetchValid)
        begin
            fetchValid <= 1'b0;
            fetchBytes <= ~fetchBytes;
        end
        else if (fetchBusy && fetchWait == 3'h0)
        begin
            fetchValid <= 1'b1;
            fetchBusy  <= 1'b0;
            fetchBytes <= mem[fetchAddr[7:4]];
        end
        else if (fetchBusy)
            fetchWait <= fetchWait - 3'h1;
        else if (fetchReq)
        begin
            fetchBusy <= 1'b1;
            fetchWait <= slow ? 3'h3 : 3'h0;
        end
    end

    // Units accept slots, stalling when slow, and report updates done.
    always @(posedge clk)
    begin
        pace       <= rst_n ? pace + 2'h1 : 2'h0;
        issueReady <= rst_n && issueValid && !issueReady
                      && (!slow || pace == 2'h3);
        updatesDone <= 1'b0;
        if (!rst_n)
            doneBusy <= 1'b0;
        else if (doneBusy && doneWait == 3'h0)
        begin
            updatesDone <= 1'b1;
            doneBusy    <= 1'b0;
        end
        else if (doneBusy)
            doneWait <= doneWait - 3'h1;
        else if (regCommit || serializeReq)
        begin
            doneBusy <= 1'b1;
            doneWait <= slow ? 3'h4 : 3'h0;
        end
    end
endmodule // fetch_exec_model

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top
    import bundle_pkg::*;
;
    // Stimulus owned by the bench.
    logic                         clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
    logic                         redirectValid = 1'b0, serializeReq = 1'b0;
    logic                         redirectEndsGroup = 1'b0;
    logic [63:0]                  redirectAddr = 64'h0;
    // Block outputs and partner answers.
    logic                         fetchReq, fetchValid, issueValid, issueReady;
    logic                         issueGroupStart, issueGroupEnd, issueNoDep;
    logic                         updatesDone, regCommit, illegalOp;
    logic [63:0]                  fetchAddr, issueAddr, faultAddr;
    logic [BUNDLE_BYTES-1:0][7:0] fetchBytes;
    logic [SLOT_BITS-1:0]         issueInstr, issueExtra;
    logic [1:0]                   issueSlot;
    unit_e                        issueUnit;
    itype_e                       issueType;
    int                           errCount = 0, nTests = 0;

    always #20 clk = ~clk;

    bundle_decode_group_sequencer DUT (.clk(clk), .rst_n(rst_n),
        .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchValid(fetchValid),
        .fetchBytes(fetchBytes), .issueValid(issueValid),
        .issueReady(issueReady), .issueInstr(issueInstr),
        .issueExtra(issueExtra), .issueUnit(issueUnit),
        .issueType(issueType), .issueAddr(issueAddr), .issueSlot(issueSlot),
        .issueGroupStart(issueGroupStart), .issueGroupEnd(issueGroupEnd),
        .issueNoDep(issueNoDep), .redirectValid(redirectValid),
        .redirectAddr(redirectAddr), .redirectEndsGroup(redirectEndsGroup),
        .serializeReq(serializeReq), .updatesDone(updatesDone),
        .regCommit(regCommit), .illegalOp(illegalOp), .faultAddr(faultAddr));

    fetch_exec_model MEM (.clk(clk), .rst_n(rst_n), .slow(slow),
        .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchValid(fetchValid),
        .fetchBytes(fetchBytes), .issueValid(issueValid),
        .issueReady(issueReady), .regCommit(regCommit),
        .serializeReq(serializeReq), .updatesDone(updatesDone));

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Compares one result and reports a mismatch at once.
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        nTests++;
        if (got !== exp)
        begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for an accepted slot, then compares its kind, place and body.
    task automatic expect_issue(input logic [10:0] kind,
        input logic [63:0] addr, input logic [81:0] body);
        int i;
        i = 0;
        do
        begin
            @(negedge clk);
            i++;
        end
        while (!(issueValid === 1'b1 && issueReady === 1'b1) && i < 300);
        if (i >= 300)
        begin
            errCount++;
            complete_run();
        end
        check(128'({issueAddr, issueSlot, issueUnit, issueType,
            issueGroupStart, issueGroupEnd, issueNoDep}), 128'({addr, kind}));
        check(128'({issueExtra, issueInstr}), 128'(body));
    endtask

    // Two bundles: slot order, ascending addresses and template stops.
    task automatic t_stream();
        expect_issue({2'h0, U_M, T_M, 3'h5}, 64'h00, {41'h0, 41'h1});
        expect_issue({2'h1, U_I, T_I, 3'h0}, 64'h00, {41'h0, 41'h2});
        expect_issue({2'h2, U_I, T_I, 3'h0}, 64'h00, {41'h0, 41'h3});
        expect_issue({2'h0, U_M, T_M, 3'h0}, 64'h10, {41'h0, 41'h4});
        expect_issue({2'h1, U_I, T_I, 3'h2}, 64'h10, {41'h0, 41'h5});
        expect_issue({2'h2, U_I, T_I, 3'h6}, 64'h10, {41'h0, 41'h6});
    endtask

    // Undefined template faults; a misaligned redirect leaves the fault.
    task automatic t_fault();
        int i;
        i = 0;
        while (illegalOp !== 1'b1 && i < 300)
        begin
            @(negedge clk);
            i++;
        end
        if (i >= 300)
        begin
            errCount++;
            complete_run();
        end
        check(128'({illegalOp, issueValid, faultAddr}), {62'h0, 2'h2, 64'h20});
        @(posedge clk);
        slow          <= 1'b1;
        redirectValid <= 1'b1;
        redirectAddr  <= 64'h4C;
        @(posedge clk);
        redirectValid <= 1'b0;
        @(negedge clk);
        check(128'({fetchReq, fetchAddr}), 128'({1'b1, 64'h40}));
    endtask

    // Long-immediate bundle: the extended pair issues once on the branch unit.
    task automatic t_long();
        expect_issue({2'h0, U_M, T_M, 3'h5}, 64'h40, {41'h0, 41'h7});
        expect_issue({2'h1, U_B, T_LX, 3'h2}, 64'h40,
            {41'h0AB_CDEF_0123, 4'hC, 37'h8});
        // A serialising op that meets the drain's update report wins,
        // so the next fetch stays held until a fresh report arrives.
        repeat (7) @(posedge clk);
        serializeReq <= 1'b1;
        @(posedge clk);
        serializeReq <= 1'b0;
        @(negedge clk);
        check(128'(fetchReq), 128'(1'b0));
    endtask

    // Branch-unit break ends the group though the template has no stop.
    task automatic t_break();
        expect_issue({2'h0, U_M, T_M, 3'h4}, 64'h50, {41'h0, 41'h9});
        @(posedge clk);
        serializeReq <= 1'b1;
        @(posedge clk);
        serializeReq <= 1'b0;
        expect_issue({2'h1, U_I, T_I, 3'h0}, 64'h50, {41'h0, 41'hA});
        expect_issue({2'h2, U_B, T_B, 3'h2}, 64'h50, {41'h0, 41'h0});
    endtask

    // Integer break in the extended slot keeps the group open; A and F types.
    task automatic t_extend();
        expect_issue({2'h0, U_M, T_M, 3'h4}, 64'h60,
            {41'h0, 41'hB});
        expect_issue({2'h1, U_I, T_I, 3'h0}, 64'h60,
            {41'h1, 41'h0});
        expect_issue({2'h0, U_M, T_A, 3'h0}, 64'h70,
            {41'h0, 41'h100_0000_0000});
        expect_issue({2'h1, U_F, T_F, 3'h0}, 64'h70,
            {41'h0, 41'h5});
    endtask

    // Loads the bundles, resets the block and runs the scenarios in turn.
    initial
    begin
        for (int k = 0; k < 16; k++)
            MEM.mem[k] = '0;
        MEM.mem[0] = {41'h3, 41'h2, 41'h1, 5'h00};
        MEM.mem[1] = {41'h6, 41'h5, 41'h4, 5'h03};
        MEM.mem[2] = {123'h0, 5'h06};
        MEM.mem[4] = {4'hC, 37'h8, 41'h0AB_CDEF_0123, 41'h7, 5'h05};
        MEM.mem[5] = {41'h0, 41'hA, 41'h9, 5'h10};
        MEM.mem[6] = {41'h0, 41'h1, 41'hB, 5'h04};
        MEM.mem[7] = {41'h0, 41'h5, 41'h100_0000_0000, 5'h0D};
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(128'({fetchReq, issueValid, regCommit, illegalOp, fetchAddr}),
            128'({4'h8, 64'h0}));
        @(posedge clk);
        rst_n <= 1'b1;
        t_stream();
        t_fault();
        t_long();
        t_break();
        t_extend();
        complete_run();
    end
endmodule // tb_top
